/* host_model.sv */
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clock,
  // Serial pins
  output logic select,
  output logic sclk,
  output logic sdin,
  input wire logic sdout
);
  initial begin
    select = 1'b0;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  // Changes land just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic open_cmd(output bit ok);
    ok = 1'b0;
    select = 1'b1;
    tick(8);
    for (int i = 0; i < 200 && !ok; i++) begin
      if (sdout === 1'b0) ok = 1'b1;
      else tick(1);
    end
  endtask
  // Four clocks a phase gives an 800 ns sclk, far above the host limit, to keep runs short
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sdin = tx[i];
      sclk = 1'b1;
      tick(4);
      rx[i] = sdout;
      sclk = 1'b0;
      tick(4);
    end
    sdin = ~sdin;
  endtask
  // Clock stands still between frames
  task automatic close_cmd();
    select = 1'b0;
    sdin = ~sdin;
    tick(6);
  endtask
endmodule

/* serial_memory_access_port.sv */
`timescale 1ns/100ps
`include "smp_consts.svh"

module serial_memory_access_port #(
  parameter int WAKE_CYCLES = `SMP_WAKE_CYC,
  parameter int WAKE_LOCK_CYCLES = `SMP_WAKE_LOCK_CYC,
  parameter int BUF_DEPTH = `SMP_BUF_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  // Serial pins
  input wire logic select,
  input wire logic sclk,
  input wire logic sdin,
  output logic sdout,
  // Pin sharing with the application
  input wire logic app_dout,
  output logic serial_mode,
  // Memory write port
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output smp_pkg::mem_addr_type mem_wr_addr,
  output smp_pkg::mem_byte_type mem_wr_data,
  input wire logic mem_busy,
  // Memory read port
  output logic mem_rd_req,
  output smp_pkg::mem_addr_type mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire smp_pkg::mem_byte_type mem_rd_data,
  // Direct commands
  output logic direct_valid,
  output logic [2:0] direct_op_index,
  output logic [2:0] direct_op_argument,
  output logic pin_lock
);
  import smp_pkg::*;

  localparam int BW = 19;

  port_state_type state_r;
  logic sel_m, sel_s, sclk_m, sclk_s, sclk_d, din_m, din_s;
  logic sclk_rise, sclk_fall, rx_state, byte_done, first_byte_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_in_r, byte_val, cmd_hi_r;
  mem_addr_type addr_r, rd_addr_r;
  logic [7:0] stage_r [`SMP_PAGE_BYTES];
  logic [3:0] offset_r;
  logic [4:0] wr_cnt_r, drain_cnt_r;
  logic [15:0] wake_cnt_r;
  logic [7:0] out_sh_r, next_r;
  logic [2:0] out_bit_r;
  logic sdout_r, lock_r, rd_req_r, drain_done;
  logic is_direct, is_write, is_read, rd_start;

  stream_if #(.WIDTH(BW)) buf_in ();
  stream_if #(.WIDTH(BW)) buf_out ();

  function automatic mem_addr_type page_addr(input mem_addr_type base, input logic [3:0] off);
    page_addr = {base[10:4], 4'(base[3:0] + off)};
  endfunction

  // Pins cross into the clock domain before any use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_m <= 1'b0;
      sel_s <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      din_m <= 1'b0;
      din_s <= 1'b0;
    end else if (enable) begin
      sel_m <= select;
      sel_s <= sel_m;
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      din_m <= sdin;
      din_s <= din_m;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d;
  assign sclk_fall = !sclk_s && sclk_d;
  assign rx_state = (state_r == ST_CMD) || (state_r == ST_WDATA);
  assign byte_val = {shift_in_r[6:0], din_s};
  assign byte_done = sel_s && rx_state && sclk_fall && (bit_cnt_r == 3'h7);
  assign is_direct = (byte_val[7:6] == `SMP_DIRECT_TAG);
  assign is_write = (cmd_hi_r[7:3] == `SMP_WR_TAG);
  assign is_read = (cmd_hi_r[7:3] == `SMP_RD_TAG);
  assign rd_start = (state_r == ST_CMD) && byte_done && !first_byte_r && is_read;

  // Bit counter; dropping select discards a partial byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 3'h0;
      shift_in_r <= 8'h00;
    end else if (enable) begin
      if (!sel_s || !rx_state) begin
        bit_cnt_r <= 3'h0;
      end else if (sclk_fall) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_in_r <= byte_val;
      end
    end
  end

  // Command sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_OFF;
      first_byte_r <= 1'b1;
      cmd_hi_r <= 8'h00;
      addr_r <= '0;
      offset_r <= 4'h0;
      wr_cnt_r <= 5'h00;
      drain_cnt_r <= 5'h00;
      wake_cnt_r <= 16'h0000;
    end else if (enable) begin
      case (state_r)
        ST_OFF: begin
          first_byte_r <= 1'b1;
          if (sel_s) begin
            // Locked port keeps its fast clock, so the wake is short
            wake_cnt_r <= lock_r ? 16'(WAKE_LOCK_CYCLES - 1) : 16'(WAKE_CYCLES - 1);
            state_r <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (!sel_s) begin
            state_r <= ST_OFF;
          end else if (wake_cnt_r == 16'h0000) begin
            state_r <= ST_CMD;
          end else begin
            wake_cnt_r <= wake_cnt_r - 16'h0001;
          end
        end
        ST_CMD: begin
          if (!sel_s) begin
            state_r <= ST_OFF;
          end else if (byte_done && first_byte_r) begin
            if (is_direct) begin
              state_r <= ST_IGNORE;
            end else begin
              cmd_hi_r <= byte_val;
              first_byte_r <= 1'b0;
            end
          end else if (byte_done) begin
            addr_r <= {cmd_hi_r[2:0], byte_val};
            offset_r <= byte_val[3:0];
            wr_cnt_r <= 5'h00;
            if (is_write) begin
              state_r <= ST_WDATA;
            end else if (is_read) begin
              state_r <= ST_RFETCH;
            end else begin
              state_r <= ST_IGNORE;
            end
          end
        end
        ST_WDATA: begin
          if (!sel_s) begin
            drain_cnt_r <= 5'h00;
            state_r <= (wr_cnt_r != 5'h00) ? ST_WDRAIN : ST_OFF;
          end else if (byte_done) begin
            offset_r <= offset_r + 4'h1;
            if (wr_cnt_r != 5'(`SMP_PAGE_BYTES)) begin
              wr_cnt_r <= wr_cnt_r + 5'h01;
            end
          end
        end
        ST_WDRAIN: begin
          // Runs on after select falls until the memory is idle
          if (buf_in.valid && buf_in.ready) begin
            drain_cnt_r <= drain_cnt_r + 5'h01;
          end
          if (drain_done) begin
            state_r <= ST_OFF;
          end
        end
        ST_RFETCH: begin
          if (!sel_s) begin
            state_r <= ST_OFF;
          end else if (mem_rd_valid) begin
            state_r <= ST_RSHIFT;
          end
        end
        ST_RSHIFT: begin
          if (!sel_s) begin
            state_r <= ST_OFF;
          end
        end
        ST_IGNORE: begin
          if (!sel_s) begin
            state_r <= ST_OFF;
          end
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end
  end

  // Page staging; a wrapped write overwrites the page start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `SMP_PAGE_BYTES; i++) begin
        stage_r[i] <= 8'h00;
      end
    end else if (enable && (state_r == ST_WDATA) && byte_done) begin
      stage_r[offset_r] <= byte_val;
    end
  end

  assign drain_done = (drain_cnt_r == wr_cnt_r) && !buf_out.valid && !mem_busy;
  assign buf_in.valid = (state_r == ST_WDRAIN) && (drain_cnt_r != wr_cnt_r);
  assign buf_in.data = {page_addr(addr_r, drain_cnt_r[3:0]), stage_r[4'(page_addr(addr_r, drain_cnt_r[3:0]))]};

  two_entry_buffer #(.WIDTH(BW), .DEPTH(BUF_DEPTH)) u_buffer (
    .clock(clock),
    .rst(rst),
    .enable(enable),
    .in_s(buf_in),
    .out_s(buf_out)
  );

  assign mem_wr_valid = buf_out.valid;
  assign buf_out.ready = mem_wr_ready;
  assign mem_wr_addr = buf_out.data[18:8];
  assign mem_wr_data = buf_out.data[7:0];

  // Read fetch and output shifting; next byte prefetched a whole byte early
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_req_r <= 1'b0;
      rd_addr_r <= '0;
      out_sh_r <= 8'h00;
      next_r <= 8'h00;
      out_bit_r <= 3'h0;
      sdout_r <= 1'b0;
    end else if (enable) begin
      rd_req_r <= 1'b0;
      if (rd_start) begin
        rd_addr_r <= {cmd_hi_r[2:0], byte_val};
        rd_req_r <= 1'b1;
      end else if (state_r == ST_RFETCH && sel_s && mem_rd_valid) begin
        out_sh_r <= mem_rd_data;
        out_bit_r <= 3'h0;
        sdout_r <= 1'b1;
        rd_addr_r <= rd_addr_r + 11'h001;
        rd_req_r <= 1'b1;
      end else if (state_r == ST_RSHIFT) begin
        if (mem_rd_valid) begin
          next_r <= mem_rd_data;
        end
        if (sclk_rise) begin
          sdout_r <= out_sh_r[7];
          out_bit_r <= out_bit_r + 3'h1;
          if (out_bit_r == 3'h7) begin
            out_sh_r <= next_r;
            rd_addr_r <= rd_addr_r + 11'h001;
            rd_req_r <= 1'b1;
          end else begin
            out_sh_r <= {out_sh_r[6:0], 1'b0};
          end
        end
      end
    end
  end

  assign mem_rd_req = rd_req_r;
  assign mem_rd_addr = rd_addr_r;

  // Direct commands and pin lock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      direct_valid <= 1'b0;
      direct_op_index <= 3'h0;
      direct_op_argument <= 3'h0;
      lock_r <= 1'b0;
    end else if (enable) begin
      direct_valid <= 1'b0;
      if ((state_r == ST_CMD) && byte_done && first_byte_r && is_direct) begin
        direct_valid <= 1'b1;
        direct_op_index <= byte_val[5:3];
        direct_op_argument <= byte_val[2:0];
        if (byte_val[5:3] == `SMP_OP_PIN_LOCK && byte_val[2:0] == `SMP_ARG_SERIAL) begin
          lock_r <= 1'b1;
        end else if (byte_val[5:3] == `SMP_OP_PIN_LOCK && byte_val[2:0] == `SMP_ARG_APP) begin
          lock_r <= 1'b0;
        end
      end
    end
  end

  assign pin_lock = lock_r;
  assign serial_mode = lock_r || (state_r != ST_OFF);
  // Busy shows high during wake and write drain; otherwise low or read data, or app_dout outside serial mode
  always_comb begin
    if (!serial_mode) begin
      sdout = app_dout;
    end else if (state_r == ST_WAKE || state_r == ST_WDRAIN) begin
      sdout = 1'b1;
    end else if (state_r == ST_RSHIFT) begin
      sdout = sdout_r;
    end else begin
      sdout = 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !enable);

  sequence s_drain_end;
    (state_r == ST_WDRAIN) ##1 (state_r == ST_OFF);
  endsequence

  property p_busy_wake;
    (state_r == ST_WAKE) |-> sdout;
  endproperty
  a_busy_wake: assert property (p_busy_wake) else $error("serial out low during wake");

  property p_write_busy;
    (state_r == ST_WDATA) && !sel_s && (wr_cnt_r != 5'h00) |=> sdout && (state_r == ST_WDRAIN);
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("write did not start busy");

  property p_lock_low;
    lock_r throughout s_drain_end |-> !sdout;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("locked port not low after write");

  property p_bit_step;
    sclk_fall && rx_state && sel_s |=> (bit_cnt_r == $past(bit_cnt_r) + 3'h1) || !sel_s;
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("bit counter did not step on fall");

  property p_out_hold;
    (state_r == ST_RSHIFT) && !sclk_rise ##1 (state_r == ST_RSHIFT) |-> $stable(sdout_r);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("read bit changed off rising edge");

  property p_page_wrap;
    buf_in.valid |-> (buf_in.data[18:12] == addr_r[10:4]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("write left its page");

  property p_first_addr;
    buf_in.valid && (drain_cnt_r == 5'h00) |-> (buf_in.data[18:8] == addr_r);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first byte not at target");

  property p_partial_drop;
    $fell(sel_s) |=> (bit_cnt_r == 3'h0);
  endproperty
  a_partial_drop: assert property (p_partial_drop) else $error("bit counter kept after select fell");

  property p_read_ready;
    (state_r == ST_RFETCH) && sel_s && mem_rd_valid |=> (state_r == ST_RSHIFT) && sdout;
  endproperty
  a_read_ready: assert property (p_read_ready) else $error("ready not shown for read");

  property p_lock_set;
    (state_r == ST_CMD) && byte_done && first_byte_r && (byte_val == 8'hc9) |=> lock_r && direct_valid;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("pin lock not taken");

  property p_read_end;
    (state_r == ST_RSHIFT) && !sel_s |=> (state_r == ST_OFF);
  endproperty
  a_read_end: assert property (p_read_end) else $error("read did not end on select low");
endmodule

/* smp_consts.svh */
`ifndef SMP_CONSTS_SVH
`define SMP_CONSTS_SVH

`define SMP_CLK_PERIOD_NS 100
`define SMP_SCLK_MAX_KHZ 100
`define SMP_WAKE_NS 150000
`define SMP_WAKE_LOCK_NS 2000
`define SMP_WAKE_CYC ((`SMP_WAKE_NS + `SMP_CLK_PERIOD_NS - 1) / `SMP_CLK_PERIOD_NS)
`define SMP_WAKE_LOCK_CYC ((`SMP_WAKE_LOCK_NS + `SMP_CLK_PERIOD_NS - 1) / `SMP_CLK_PERIOD_NS)

`define SMP_PAGE_BYTES 16
`define SMP_BUF_DEPTH 2
`define SMP_WR_TAG 5'h00
`define SMP_RD_TAG 5'h08
`define SMP_DIRECT_TAG 2'h3
`define SMP_OP_PIN_LOCK 3'h1
`define SMP_ARG_SERIAL 3'h1
`define SMP_ARG_APP 3'h0

`endif

/* smp_pkg.sv */
package smp_pkg;

  typedef logic [10:0] mem_addr_type;
  typedef logic [7:0] mem_byte_type;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAKE,
    ST_CMD,
    ST_WDATA,
    ST_WDRAIN,
    ST_RFETCH,
    ST_RSHIFT,
    ST_IGNORE
  } port_state_type;

endpackage

/* stream_if.sv */
`timescale 1ns/100ps

interface stream_if #(
  parameter int WIDTH = 19
) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import smp_pkg::*;
  logic clock, rst, enable, app_dout, select, sclk, sdin, sdout, serial_mode;
  logic mem_wr_valid, mem_rd_req, direct_valid, pin_lock;
  logic mem_wr_ready, mem_busy, mem_rd_valid;
  mem_byte_type mem_rd_data;
  mem_addr_type mem_wr_addr, mem_rd_addr;
  mem_byte_type mem_wr_data;
  logic [2:0] direct_op_index, direct_op_argument, bc = 3'h0;
  mem_byte_type mem [2048];
  mem_byte_type ref_m [2048];
  int n_mismatch = 0, tests_run = 0, seed = 10, n_wr = 0, n_dv = 0;
  serial_memory_access_port #(.WAKE_CYCLES(4), .WAKE_LOCK_CYCLES(2), .BUF_DEPTH(2)) DUT (
    .clock, .rst, .enable, .select, .sclk, .sdin, .sdout, .app_dout, .serial_mode,
    .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_busy,
    .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
    .direct_valid, .direct_op_index, .direct_op_argument, .pin_lock);
  host_model host (.clock, .select, .sclk, .sdin, .sdout);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Memory stalls at random and stays busy a while after each word
  always @(posedge clock) begin
    if (rst) begin
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 8'h00;
      mem_wr_ready <= 1'b0;
      mem_busy <= 1'b0;
    end else begin
      mem_rd_valid <= mem_rd_req;
      if (mem_rd_req) mem_rd_data <= mem[mem_rd_addr];
      if (mem_wr_valid && mem_wr_ready) begin
        mem[mem_wr_addr] <= mem_wr_data;
        n_wr <= n_wr + 1;
        bc <= 3'h3;
      end else if (bc != 3'h0) bc <= bc - 3'h1;
      mem_busy <= (mem_wr_valid && mem_wr_ready) || bc > 3'h1;
      mem_wr_ready <= bc == 3'h0 && !(mem_wr_valid && mem_wr_ready) && ($random(seed) % 3 != 0);
      if (direct_valid === 1'b1) n_dv <= n_dv + 1;
    end
  end
  function automatic mem_addr_type wr_at(input mem_addr_type a, input int k);
    return {a[10:4], a[3:0] + 4'(k)};
  endfunction
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_lvl(input logic v, input int lim, input string what);
    int i;
    i = 0;
    while (sdout !== v && i < lim) begin
      host.tick(1);
      i++;
    end
    cmp_bit(sdout, v, what);
  endtask
  task automatic do_write(input logic [7:0] c0, input mem_addr_type a, input int n);
    bit ok;
    logic [7:0] rx, d;
    int w0;
    w0 = n_wr;
    host.open_cmd(ok);
    cmp_bit(ok, 1'b1, "ready");
    host.shift(c0 | 8'(a[10:8]), 8, rx);
    host.shift(a[7:0], 8, rx);
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      if (c0 == 8'h00) ref_m[wr_at(a, k)] = d;
      host.shift(d, 8, rx);
    end
    host.close_cmd();
    if (c0 == 8'h00) wait_lvl(1'b1, 20, "busy");
    wait_lvl(1'b0, 300, "done");
    host.tick(4);
    cmp_byte(8'(n_wr - w0), c0 != 8'h00 ? 8'h00 : n > 16 ? 8'h10 : 8'(n), "words");
  endtask
  task automatic do_read(input mem_addr_type a, input int n);
    bit ok;
    logic [7:0] rx;
    host.open_cmd(ok);
    host.shift(8'h40 | 8'(a[10:8]), 8, rx);
    host.shift(a[7:0], 8, rx);
    wait_lvl(1'b1, 60, "rd ready");
    for (int k = 0; k < n; k++) begin
      host.shift(8'($random(seed)), 8, rx);
      cmp_byte(rx, ref_m[mem_addr_type'(a + k)], "rd data");
    end
    host.close_cmd();
    cmp_bit(sdout, app_dout, "pin back");
  endtask
  task automatic do_direct(input logic [7:0] b);
    bit ok;
    logic [7:0] rx;
    int d0;
    d0 = n_dv;
    host.open_cmd(ok);
    host.shift(b, 8, rx);
    host.close_cmd();
    cmp_byte(8'(n_dv - d0), 8'h01, "pulse");
    cmp_byte({2'b11, direct_op_index, direct_op_argument}, b, "direct");
  endtask
  task automatic give_verdict();
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [7:0] rx;
    bit ok;
    mem_addr_type a;
    rst = 1'b1;
    enable = 1'b1;
    app_dout = 1'b0;
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
      ref_m[i] = 8'(i) ^ 8'h5a;
    end
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    host.tick(2);
    cmp_bit(serial_mode, 1'b0, "idle mode");
    do_write(8'h00, 11'h123, 3);
    do_read(11'h123, 3);
    $display("test plain done");
    do_write(8'h00, 11'h2fe, 18);
    do_read(11'h2f0, 17);
    $display("test wrap done");
    for (int t = 0; t < 4; t++) begin
      a = 11'($random(seed));
      do_write(8'h00, a, 1 + ($unsigned($random(seed)) % (16 - a[3:0])));
      do_read(a - 11'h1, 4);
    end
    $display("test random done");
    do_write(8'h10, 11'h050, 2);
    do_read(11'h050, 2);
    host.open_cmd(ok);
    host.shift(8'hff, 5, rx);
    host.close_cmd();
    do_write(8'h00, 11'h404, 1);
    do_read(11'h403, 3);
    $display("test refuse done");
    // Frozen port must not notice a select
    enable = 1'b0;
    host.open_cmd(ok);
    cmp_bit(serial_mode, 1'b0, "frozen");
    host.close_cmd();
    enable = 1'b1;
    host.tick(2);
    $display("test freeze done");
    for (int i = 0; i < 8; i++) begin
      do_direct({2'b11, 3'(i), i == 1 ? 3'h0 : 3'($random(seed))});
      cmp_bit(pin_lock, 1'b0, "no lock");
    end
    do_direct(8'hc9);
    cmp_bit(pin_lock, 1'b1, "lock");
    cmp_bit(serial_mode, 1'b1, "locked mode");
    app_dout = 1'b1;
    do_write(8'h00, 11'h7a0, 2);
    cmp_bit(sdout, 1'b0, "locked idle");
    do_direct(8'hc8);
    cmp_bit(pin_lock, 1'b0, "unlock");
    cmp_bit(sdout, app_dout, "app pin");
    app_dout = 1'b0;
    do_read(11'h7a0, 2);
    $display("test direct done");
    give_verdict();
  end
endmodule

/* two_entry_buffer.sv */
`timescale 1ns/100ps

module two_entry_buffer #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  // Streams
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [IW-1:0] wr_idx_r;
  logic [IW-1:0] rd_idx_r;
  logic [IW:0] count_r;
  logic push;
  logic pop;

  function automatic logic [IW-1:0] next_idx(input logic [IW-1:0] idx);
    next_idx = (idx == IW'(DEPTH - 1)) ? '0 : idx + 1'b1;
  endfunction

  assign in_s.ready = (count_r != (IW + 1)'(DEPTH));
  assign out_s.valid = (count_r != '0);
  assign out_s.data = mem_r[rd_idx_r];
  assign push = enable && in_s.valid && in_s.ready;
  assign pop = enable && out_s.valid && out_s.ready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_idx_r] <= in_s.data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_idx_r <= next_idx(wr_idx_r);
      end
      if (pop) begin
        rd_idx_r <= next_idx(rd_idx_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
